// ### core/led_sink_regs.svh
// Constants for the serial LED sink driver: timing, widths and limits
`ifndef LED_SINK_REGS_SVH
`define LED_SINK_REGS_SVH

`define CH_COUNT 16
`define CLK_HZ 25000000
`define CLK_PER_MS (`CLK_HZ / 1000)
`define INACTIVITY_TIMEOUT_MS 1000
`define INACTIVITY_TIMEOUT_MIN_MS 100
`define INACTIVITY_TIMEOUT_MAX_MS 2500
`define INACTIVITY_TIMEOUT_CYC (`CLK_PER_MS * `INACTIVITY_TIMEOUT_MS)
`define INACTIVITY_TIMEOUT_MAX_CYC (`CLK_PER_MS * `INACTIVITY_TIMEOUT_MAX_MS)
`define FAULT_LOG_DEPTH 16
`define CHAN_ALL_OFF 16'h0000

`endif

// ### core/led_sink_pkg.sv
// Types shared by the serial LED sink driver
package led_sink_pkg;
	typedef logic [15:0] chan_word_t;
	typedef enum logic [1:0] {
		WD_RUN = 2'b00,
		WD_BLANK = 2'b01
	} wd_state_t;
endpackage

// ### core/serial_led_sink.sv
// Serial LED sink driver: shift path, output latch, fault capture, watchdog, fault log FIFO
`timescale 1ns/1ps
`include "led_sink_regs.svh"
// Summary of operation
// - Host shifts one bit per clock, 16-bit register
// - Input bit reaches cascade output 16 clocks later
// - Strobe copies shift register into output latch
// - High output-enable blanks all channels, fast
// - Open-circuit fault tracked per channel while it sinks current
// - Strobe rise loads fault status into register
// - Faults shift out during next transmission
// - Interface idle past timeout clears output latch
// - Timeout leaves shift register untouched
// - Outputs stay off until next latch transfer
// - Data sampled on rising serial clock edge
// - Latch transparent when strobe high, holds when low

////////////////////////////////////////////////////////////////////////////////
// Fault log FIFO
module led_fault_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = `FAULT_LOG_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
		$error("FIFO depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	function automatic logic [AW:0] ptr_next(input logic [AW:0] p);
		return p + {{AW{1'b0}}, 1'b1};
	endfunction

	assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= ptr_next(wr_ptr_r);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= ptr_next(rd_ptr_r);
		end
	end

	fifo_no_overrun_a: assert property (@(posedge clk) disable iff (!rst_n)
		!in_ready |=> (wr_ptr_r == $past(wr_ptr_r)))
		else $error("FIFO write pointer moved while full");
endmodule

////////////////////////////////////////////////////////////////////////////////
// Driver core
module serial_led_sink #(
	parameter int unsigned WDOG_CYCLES = `INACTIVITY_TIMEOUT_CYC,
	parameter int LOG_DEPTH = `FAULT_LOG_DEPTH
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial link
	input wire logic sclk,
	input wire logic din,
	input wire logic latch_strobe,
	input wire logic oe_n,
	output logic dout,
	// Channel pads
	input wire led_sink_pkg::chan_word_t open_det,
	output led_sink_pkg::chan_word_t sink_on,
	// Fault log
	output logic fault_log_valid,
	input wire logic fault_log_ready,
	output led_sink_pkg::chan_word_t fault_log_data
);
	import led_sink_pkg::*;

	localparam int CW = $clog2(WDOG_CYCLES + 1);

	// Simulation may shorten the timeout; it may never exceed the upper bound
	if (WDOG_CYCLES < 2 || WDOG_CYCLES > `INACTIVITY_TIMEOUT_MAX_CYC) begin : g_bad_wdog
		$error("Watchdog cycle count out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Link clock domain
	chan_word_t sreg_r;
	logic dout_r;
	logic act_tog_r;
	logic load_s1_r;
	logic load_s2_r;
	logic load_ack_r;
	logic load_now;
	// Written in the system domain, read here only after the toggle handshake
	chan_word_t fault_snap_r;
	logic load_tog_r;

	assign load_now = load_s2_r ^ load_ack_r;
	assign dout = dout_r;

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			load_s1_r <= 1'b0;
			load_s2_r <= 1'b0;
		end else begin
			load_s1_r <= load_tog_r;
			load_s2_r <= load_s1_r;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			load_ack_r <= 1'b0;
		end else begin
			load_ack_r <= load_s2_r;
		end
	end

	// Only this domain writes the shift register, so the watchdog cannot touch it
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			sreg_r <= `CHAN_ALL_OFF;
			dout_r <= 1'b0;
		end else if (load_now) begin
			sreg_r <= {fault_snap_r[14:0], din};
			dout_r <= fault_snap_r[15];
		end else begin
			sreg_r <= {sreg_r[14:0], din};
			dout_r <= sreg_r[15];
		end
	end

	// Every rising link clock edge is reported as activity
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			act_tog_r <= 1'b0;
		end else begin
			act_tog_r <= ~act_tog_r;
		end
	end

	shift_in_a: assert property (@(posedge sclk) disable iff (!rst_n)
		1'b1 |=> sreg_r[0] == $past(din))
		else $error("Serial input not sampled into bit 0");

	cascade_step_a: assert property (@(posedge sclk) disable iff (!rst_n)
		!load_now ##1 !load_now |=> dout_r == $past(sreg_r[15], 1))
		else $error("Cascade output not fed from top shift bit");

	shift_walk_a: assert property (@(posedge sclk) disable iff (!rst_n)
		!load_now [*3] |=> sreg_r[2:0] == {$past(din, 3), $past(din, 2), $past(din, 1)})
		else $error("Shift register order broken");

	fault_load_a: assert property (@(posedge sclk) disable iff (!rst_n)
		load_now |=> sreg_r[15:1] == $past(fault_snap_r[14:0])
			&& dout_r == $past(fault_snap_r[15]))
		else $error("Fault word not loaded into shift register");

	fault_out_a: assert property (@(posedge sclk) disable iff (!rst_n)
		load_now ##1 !load_now |=> dout_r == $past(fault_snap_r[14], 2))
		else $error("Second fault bit not shifted out");

	////////////////////////////////////////////////////////////////////////////
	// System domain input synchronisers
	logic ls_s1_r;
	logic ls_s2_r;
	logic ls_d_r;
	logic oe_s1_r;
	logic oe_s2_r;
	logic act_s1_r;
	logic act_s2_r;
	logic act_d_r;
	chan_word_t od_s1_r;
	chan_word_t od_s2_r;
	logic strobe_rise;
	logic strobe_edge;
	logic activity;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ls_s1_r <= 1'b0;
			ls_s2_r <= 1'b0;
			ls_d_r <= 1'b0;
		end else begin
			ls_s1_r <= latch_strobe;
			ls_s2_r <= ls_s1_r;
			ls_d_r <= ls_s2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_s1_r <= 1'b1;
			oe_s2_r <= 1'b1;
		end else begin
			oe_s1_r <= oe_n;
			oe_s2_r <= oe_s1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_s1_r <= 1'b0;
			act_s2_r <= 1'b0;
			act_d_r <= 1'b0;
		end else begin
			act_s1_r <= act_tog_r;
			act_s2_r <= act_s1_r;
			act_d_r <= act_s2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			od_s1_r <= `CHAN_ALL_OFF;
			od_s2_r <= `CHAN_ALL_OFF;
		end else begin
			od_s1_r <= open_det;
			od_s2_r <= od_s1_r;
		end
	end

	assign strobe_rise = ls_s2_r && !ls_d_r;
	assign strobe_edge = ls_s2_r ^ ls_d_r;
	assign activity = (act_s2_r ^ act_d_r) || strobe_edge;

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	wd_state_t wd_state_r;
	logic [CW-1:0] wd_cnt_r;
	logic wd_expire;

	assign wd_expire = (wd_state_r == WD_RUN) && !activity
		&& (wd_cnt_r == CW'(WDOG_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_r <= '0;
		end else if (activity || wd_state_r != WD_RUN) begin
			wd_cnt_r <= '0;
		end else if (!wd_expire) begin
			wd_cnt_r <= wd_cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_state_r <= WD_RUN;
		end else begin
			case (wd_state_r)
				WD_RUN: begin
					if (wd_expire) begin
						wd_state_r <= WD_BLANK;
					end
				end
				WD_BLANK: begin
					if (strobe_rise) begin
						wd_state_r <= WD_RUN;
					end
				end
				default: begin
					wd_state_r <= WD_BLANK;
				end
			endcase
		end
	end

	wd_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		activity |=> wd_cnt_r == '0)
		else $error("Activity did not restart watchdog");

	wd_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		wd_cnt_r <= CW'(WDOG_CYCLES - 1))
		else $error("Watchdog count ran past its limit");

	////////////////////////////////////////////////////////////////////////////
	// Output latch and channel drive
	chan_word_t latch_r;
	chan_word_t sink_on_r;

	// Strobe held high means the link clock is idle, so the word is stable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_r <= `CHAN_ALL_OFF;
		end else if (wd_expire || (wd_state_r == WD_BLANK && !strobe_rise)) begin
			latch_r <= `CHAN_ALL_OFF;
		end else if (ls_s2_r && ls_d_r) begin
			latch_r <= sreg_r;
		end
	end

	// A set latch bit sinks current unless output enable is high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sink_on_r <= `CHAN_ALL_OFF;
		end else begin
			sink_on_r <= latch_r & {16{~oe_s2_r}};
		end
	end

	assign sink_on = sink_on_r;

	latch_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ls_s2_r && ls_d_r && wd_state_r == WD_RUN && !wd_expire) |=> latch_r == $past(sreg_r))
		else $error("Latch not transparent while strobe high");

	latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!ls_s2_r && !wd_expire && wd_state_r == WD_RUN) |=> $stable(latch_r))
		else $error("Latch changed while strobe low");

	oe_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		oe_s2_r |=> sink_on_r == `CHAN_ALL_OFF)
		else $error("Channel on while output enable inactive");

	oe_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
		!oe_s2_r |=> sink_on_r == $past(latch_r))
		else $error("Enabled channels do not follow latch");

	wd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		wd_expire |=> latch_r == `CHAN_ALL_OFF ##1 sink_on_r == `CHAN_ALL_OFF)
		else $error("Watchdog expiry did not blank outputs");

	blank_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(wd_state_r == WD_BLANK && !strobe_rise) |=> (wd_state_r == WD_BLANK)
			&& latch_r == `CHAN_ALL_OFF)
		else $error("Outputs left blank without a latch transfer");

	////////////////////////////////////////////////////////////////////////////
	// Open-circuit fault tracking and capture
	chan_word_t fault_r;
	logic push_pend_r;
	logic log_in_ready;

	// Open detection is only meaningful while the channel sinks current
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_r <= `CHAN_ALL_OFF;
		end else begin
			fault_r <= (od_s2_r & sink_on_r) | (fault_r & ~sink_on_r);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_snap_r <= `CHAN_ALL_OFF;
		end else if (strobe_rise) begin
			fault_snap_r <= fault_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_tog_r <= 1'b0;
		end else if (strobe_rise) begin
			load_tog_r <= ~load_tog_r;
		end
	end

	// New capture wins over a push that completes in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			push_pend_r <= 1'b0;
		end else if (strobe_rise) begin
			push_pend_r <= 1'b1;
		end else if (log_in_ready) begin
			push_pend_r <= 1'b0;
		end
	end

	led_fault_fifo #(
		.WIDTH(16),
		.DEPTH(LOG_DEPTH)
	) u_fault_log (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_pend_r),
		.in_ready(log_in_ready),
		.in_data(fault_snap_r),
		.out_valid(fault_log_valid),
		.out_ready(fault_log_ready),
		.out_data(fault_log_data)
	);

	fault_track_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (fault_r & $past(sink_on_r)) == ($past(od_s2_r) & $past(sink_on_r)))
		else $error("Fault status does not track open detect");

	fault_snap_a: assert property (@(posedge clk) disable iff (!rst_n)
		strobe_rise |=> fault_snap_r == $past(fault_r) && load_tog_r != $past(load_tog_r))
		else $error("Fault status not captured on strobe rise");
endmodule

// ### tb/led_host.sv
// Host-side model of the serial LED sink link: frames and strobe pulses
`timescale 1ns/1ps
module led_host (
	// System clock
	input wire logic clk,
	// Serial link
	output logic sclk,
	output logic din,
	output logic latch_strobe,
	input wire logic dout
);
	initial begin
		sclk = 1'b0;
		din = 1'b0;
		latch_strobe = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift n bits, oldest first; dout sampled just after each rising edge
	task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] rd);
		rd = '0;
		@(posedge clk);
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			din = bits[i];
			#7.5 sclk = 1'b1;
			#1 rd = {rd[30:0], dout};
			#6.5 sclk = 1'b0;
		end
		// Released line must not keep its last level
		din = ~din;
	endtask

	// Strobe high long enough to pass the synchroniser, sclk stopped meanwhile
	task automatic pulse();
		@(posedge clk);
		latch_strobe <= 1'b1;
		repeat (4) @(posedge clk);
		latch_strobe <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the serial LED sink driver
`timescale 1ns/1ps
module tb_top;
	import led_sink_pkg::*;
	logic clk;
	logic rst_n;
	logic oe_n;
	logic fault_log_ready;
	chan_word_t open_det;
	wire logic sclk;
	wire logic din;
	wire logic latch_strobe;
	wire logic dout;
	wire logic fault_log_valid;
	chan_word_t sink_on;
	chan_word_t fault_log_data;
	chan_word_t r_w, a_w, c_w, d_w, f_w;
	chan_word_t notes[$];
	logic [31:0] rd;
	int fails = 0;
	int checked = 0;
	int cyc = 0;

	serial_led_sink #(.WDOG_CYCLES(200), .LOG_DEPTH(16)) i_serial_led_sink (
		.clk(clk), .rst_n(rst_n), .sclk(sclk), .din(din), .latch_strobe(latch_strobe),
		.oe_n(oe_n), .dout(dout), .open_det(open_det), .sink_on(sink_on),
		.fault_log_valid(fault_log_valid), .fault_log_ready(fault_log_ready),
		.fault_log_data(fault_log_data));
	led_host i_led_host (.clk(clk), .sclk(sclk), .din(din), .latch_strobe(latch_strobe),
		.dout(dout));

	always #20 clk = ~clk;

	task automatic check(input string name, input chan_word_t seen, input chan_word_t exp);
		checked++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", name, exp, seen);
			fails++;
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Fault log words compared against the oldest note
	always @(posedge clk) begin
		if (fault_log_valid === 1'b1 && fault_log_ready === 1'b1) begin
			if (notes.size() == 0) begin
				$display("BAD fault_log_data exp none seen %h", fault_log_data);
				fails++;
			end else
				check("fault_log_data", fault_log_data, notes.pop_front());
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		oe_n = 1'b0;
		open_det = '0;
		fault_log_ready = 1'b0;
		void'($urandom(32'h717b));
		{r_w, a_w} = $urandom();
		c_w = $urandom();
		d_w = $urandom();
		f_w = $urandom();
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		i_led_host.frame({r_w, a_w}, 32, rd);
		check("cascade", rd[15:0], r_w);
		i_led_host.pulse();
		notes.push_back(16'h0000);
		check("latch", sink_on, a_w);
		open_det <= f_w;
		repeat (6) @(posedge clk);
		i_led_host.frame({16'h0000, a_w}, 18, rd);
		check("fault idle", rd[15:0], 16'h0000);
		i_led_host.pulse();
		notes.push_back(f_w & a_w);
		i_led_host.frame({16'h0000, c_w}, 18, rd);
		check("fault read", rd[15:0], f_w & a_w);
		i_led_host.pulse();
		notes.push_back(f_w & a_w);
		check("latch next", sink_on, c_w);
		open_det <= '0;
		repeat (6) @(posedge clk);
		i_led_host.frame({16'h0000, c_w}, 18, rd);
		check("fault again", rd[15:0], f_w & a_w);
		repeat (180) @(posedge clk);
		check("no early blank", sink_on, c_w);
		oe_n <= 1'b1;
		repeat (5) @(posedge clk);
		check("oe blank", sink_on, 16'h0000);
		oe_n <= 1'b0;
		repeat (5) @(posedge clk);
		check("oe on", sink_on, c_w);
		repeat (30) @(posedge clk);
		check("wd blank", sink_on, 16'h0000);
		i_led_host.frame({16'h0000, d_w}, 16, rd);
		check("wd keeps shift", rd[15:0], c_w);
		repeat (6) @(posedge clk);
		check("stay off", sink_on, 16'h0000);
		i_led_host.pulse();
		notes.push_back(f_w & a_w & ~c_w);
		check("recover", sink_on, d_w);
		// Fill the log past full; the pending push keeps only the newest snapshot
		for (int i = 5; i <= 18; i++) begin
			i_led_host.pulse();
			if (i != 17)
				notes.push_back(f_w & a_w & ~c_w & ~d_w);
		end
		check("log full", {15'h0000, fault_log_valid}, 16'h0001);
		fault_log_ready <= 1'b1;
		for (int i = 0; i < 100 && notes.size() > 0; i++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		check("log empty", {15'h0000, fault_log_valid}, 16'h0000);
		check("log count", 16'(notes.size()), 16'h0000);
		report_and_stop();
	end
endmodule
